// >>> core/csr_pkg.sv
/*
  Shared constants and types for the core status registers and interrupt entry.
  Assumes a single system clock and a core that presents one special-function access per cycle.
*/
// Notes on behaviour
// RULE1: Stack pointer resets to 0x07.
// RULE2: Push increments pointer, then writes byte.
// RULE3: Two bytes form 16-bit data pointer, reset zero.
// RULE4: Carry flag from addition carry or subtraction borrow.
// RULE5: Nibble carry from carry into upper nibble.
// RULE6: Two status bits pick one of four banks.
// RULE7: Overflow on signed overflow, big product, zero divisor.
// RULE8: Those instructions otherwise clear the overflow flag.
// RULE9: Parity bit read-only, odd accumulator ones.
// RULE10: Two user flags change only by software.
// RULE11: Accumulator and second operand reset to zero.
// RULE12: Software writes zero to reserved bits.
// RULE13: Pending flag sets on event regardless of enable.
// RULE14: Enabled pending request calls vector after instruction.
// RULE15: Return resumes the interrupted instruction stream.
// RULE16: Disabled sources are ignored for dispatch.
// RULE17: Global enable gates all individual enables.
// RULE18: Hardware clears only designated pending flags.
// RULE19: Still-pending flag re-enters after one instruction.
// RULE20: Software setting a pending flag requests too.
// RULE21: Several sources, each with two priority levels.
// RULE22: High preempts low; high never preempted.
// RULE23: Detect one cycle, then five-cycle call.
// RULE24: Software write beats same-cycle hardware flag update.
package csr_pkg;
  localparam logic [7:0] ADR_SP   = 8'h81;
  localparam logic [7:0] ADR_DPL  = 8'h82;
  localparam logic [7:0] ADR_DPH  = 8'h83;
  localparam logic [7:0] ADR_PEND = 8'h9f;
  localparam logic [7:0] ADR_IE   = 8'ha8;
  localparam logic [7:0] ADR_IP   = 8'hb8;
  localparam logic [7:0] ADR_PSW  = 8'hd0;
  localparam logic [7:0] ADR_ACC  = 8'he0;
  localparam logic [7:0] ADR_B    = 8'hf0;

  localparam logic [7:0] RST_SP   = 8'h07;
  localparam logic [7:0] ZERO8    = 8'h00;
  localparam logic [7:0] STK_STEP = 8'h01;

  localparam int PSW_CY  = 7;
  localparam int PSW_AC  = 6;
  localparam int PSW_RS1 = 4;
  localparam int PSW_RS0 = 3;
  localparam int PSW_OV  = 2;
  localparam int PSW_F1  = 1;
  localparam int PSW_PAR = 0;
  localparam int IE_EA   = 7;

  localparam logic [2:0]  BANK_PAD  = 3'h0;
  localparam logic [15:0] VEC_BASE  = 16'h0003;
  localparam int          VEC_SHIFT = 3;
  localparam logic [2:0]  CALL_CYC  = 3'h5;
  localparam logic [2:0]  CNT_ONE   = 3'h1;
  localparam logic [2:0]  CNT_ZERO  = 3'h0;

  localparam int         NUM_SRC_DEF = 7;
  localparam logic [6:0] HW_CLR_DEF  = 7'h0f;

  typedef enum logic [2:0] {OP_ADD, OP_ADDC, OP_SUBB, OP_MUL, OP_DIV, OP_OTHER} csr_op_e;
  typedef enum logic {ST_IDLE, ST_CALL} csr_st_e;
endpackage

// >>> core/csr_arb_if.sv
/*
  Interface between the register block and its priority arbiter.
  Assumes both ends run on the same system clock; all signals are combinational.
*/
`timescale 1ns/1ps
`default_nettype none
interface csr_arb_if #(parameter int N = 7) ();
  localparam int IW = $clog2(N);
  logic [N-1:0]  pend_en;
  logic [N-1:0]  prio;
  logic          svc_lo;
  logic          svc_hi;
  logic          req;
  logic [IW-1:0] idx;
  logic          hi;
  modport regs (output pend_en, output prio, output svc_lo, output svc_hi,
                input req, input idx, input hi);
  modport arb (input pend_en, input prio, input svc_lo, input svc_hi,
               output req, output idx, output hi);
endinterface
`default_nettype wire

// >>> core/csr_arb.sv
/*
  Two-level priority arbiter for interrupt requests.
  Assumes enabled, pending requests arrive already gated by the global enable.
*/
`timescale 1ns/1ps
`default_nettype none
module csr_arb (
  csr_arb_if.arb a
);
  localparam int N  = $bits(a.pend_en);
  localparam int IW = $bits(a.idx);

  // Loops run downward so that the lowest index is assigned last and wins a tie.
  always_comb begin
    a.req = 1'b0;
    a.idx = '0;
    a.hi  = 1'b0;
    for (int i = N - 1; i >= 0; i--) begin
      if (a.pend_en[i] && !a.prio[i] && !a.svc_lo && !a.svc_hi) begin // [RULE22]
        a.req = 1'b1;
        a.idx = IW'(i);
        a.hi  = 1'b0;
      end
    end
    for (int i = N - 1; i >= 0; i--) begin
      if (a.pend_en[i] && a.prio[i] && !a.svc_hi) begin // [RULE21] [RULE22]
        a.req = 1'b1;
        a.idx = IW'(i);
        a.hi  = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> core/csr_core_regs.sv
/*
  Core status registers (pointers, status word, operand registers) and interrupt entry.
  Assumes the core supplies one special-function access per cycle, flags per arithmetic
  operation, and pulses marking instruction completion and interrupt return.
*/
`timescale 1ns/1ps
`default_nettype none
module csr_core_regs #(
  parameter int                         N      = csr_pkg::NUM_SRC_DEF,
  parameter logic [N-1:0]               HW_CLR = csr_pkg::HW_CLR_DEF
) (
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire logic [7:0]               sfr_addr,
  input  wire logic                     sfr_wr,
  input  wire logic [7:0]               sfr_wdata,
  input  wire logic                     sfr_rd,
  output logic      [7:0]               sfr_rdata,
  input  wire logic                     op_valid,
  input  wire csr_pkg::csr_op_e         op_kind,
  input  wire logic                     op_cy,
  input  wire logic                     op_ac,
  input  wire logic                     op_sovf,
  input  wire logic [7:0]               op_mul_hi,
  input  wire logic                     acc_wr,
  input  wire logic [7:0]               acc_data,
  input  wire logic                     push_req,
  input  wire logic [7:0]               push_data,
  input  wire logic                     pop_req,
  output logic                          stk_wr_en,
  output logic      [7:0]               stk_wr_addr,
  output logic      [7:0]               stk_wr_data,
  output logic      [7:0]               stack_top_pointer,
  output logic      [15:0]              data_ptr_16,
  output logic      [4:0]               bank_base,
  input  wire logic [N-1:0]             irq_event,
  input  wire logic                     instr_done,
  input  wire logic                     reti_done,
  output logic                          irq_call,
  output logic      [15:0]              irq_vector
);
  import csr_pkg::*;

  typedef struct packed {
    csr_st_e      st;
    logic [2:0]   cnt;
    logic [7:0]   sp;
    logic [7:0]   data_ptr_low_byte;
    logic [7:0]   data_ptr_high_byte;
    logic [7:0]   program_status_word;
    logic [7:0]   acc;
    logic [7:0]   b;
    logic [7:0]   ie;
    logic [7:0]   ip;
    logic [N-1:0] pend;
    logic         svc_lo;
    logic         svc_hi;
    logic [7:0]   rdata;
    logic         call;
    logic [15:0]  vec;
    logic         wr_en;
    logic [7:0]   wr_adr;
    logic [7:0]   wr_dat;
  } csr_regs_s;

  csr_regs_s r_r;
  csr_regs_s r_nxt;

  csr_arb_if #(.N(N)) ai ();

  csr_arb u_arb (
    .a (ai.arb)
  );

  // Disabled sources and a cleared global enable never reach the arbiter.
  assign ai.pend_en = r_r.pend & r_r.ie[N-1:0] & {N{r_r.ie[IE_EA]}}; // [RULE16] [RULE17]
  assign ai.prio    = r_r.ip[N-1:0];
  assign ai.svc_lo  = r_r.svc_lo;
  assign ai.svc_hi  = r_r.svc_hi;

  always_comb begin
    r_nxt       = r_r;
    r_nxt.call  = 1'b0;
    r_nxt.wr_en = 1'b0;

    if (op_valid) begin
      r_nxt.program_status_word[PSW_CY] = op_cy; // [RULE4]
      r_nxt.program_status_word[PSW_AC] = op_ac; // [RULE5]
      unique case (op_kind)
        OP_ADD, OP_ADDC, OP_SUBB: r_nxt.program_status_word[PSW_OV] = op_sovf; // [RULE7] [RULE8]
        OP_MUL:   r_nxt.program_status_word[PSW_OV] = (op_mul_hi != ZERO8); // [RULE7] [RULE8]
        OP_DIV:   r_nxt.program_status_word[PSW_OV] = (r_r.b == ZERO8); // [RULE7] [RULE8]
        OP_OTHER: r_nxt.program_status_word[PSW_OV] = r_r.program_status_word[PSW_OV];
        default:  r_nxt.program_status_word[PSW_OV] = r_r.program_status_word[PSW_OV];
      endcase
    end

    if (acc_wr) begin
      r_nxt.acc = acc_data;
    end

    // The new top is written only after the pointer has moved up.
    if (push_req) begin
      r_nxt.sp     = r_r.sp + STK_STEP; // [RULE2]
      r_nxt.wr_en  = 1'b1;
      r_nxt.wr_adr = r_r.sp + STK_STEP; // [RULE2]
      r_nxt.wr_dat = push_data;
    end else if (pop_req) begin
      r_nxt.sp = r_r.sp - STK_STEP;
    end

    unique case (r_r.st)
      ST_IDLE: begin
        // A return boundary never dispatches, so one more instruction runs first.
        if (instr_done && !reti_done && ai.req) begin // [RULE14] [RULE19] [RULE23]
          r_nxt.st  = ST_CALL;
          r_nxt.cnt = CALL_CYC - CNT_ONE;
          r_nxt.vec = VEC_BASE | (16'(ai.idx) << VEC_SHIFT);
          if (HW_CLR[ai.idx]) begin
            r_nxt.pend[ai.idx] = 1'b0; // [RULE18]
          end
          if (ai.hi) begin
            r_nxt.svc_hi = 1'b1; // [RULE22]
          end else begin
            r_nxt.svc_lo = 1'b1;
          end
        end
      end
      ST_CALL: begin
        if (r_r.cnt == CNT_ZERO) begin
          r_nxt.st   = ST_IDLE;
          r_nxt.call = 1'b1; // [RULE23]
        end else begin
          r_nxt.cnt = r_r.cnt - CNT_ONE;
        end
      end
    endcase

    // Return drops the innermost level; the core restores its own program counter.
    if (reti_done) begin // [RULE15]
      if (r_r.svc_hi) begin
        r_nxt.svc_hi = 1'b0;
      end else begin
        r_nxt.svc_lo = 1'b0;
      end
    end

    // Software writes come after the flag, stack and interrupt-state updates so that they take precedence over those.
    if (sfr_wr) begin
      case (sfr_addr)
        ADR_SP:   r_nxt.sp  = sfr_wdata;
        ADR_DPL:  r_nxt.data_ptr_low_byte = sfr_wdata; // [RULE3]
        ADR_DPH:  r_nxt.data_ptr_high_byte = sfr_wdata; // [RULE3]
        ADR_PSW:  r_nxt.program_status_word[PSW_CY:PSW_F1] = sfr_wdata[PSW_CY:PSW_F1]; // [RULE24] [RULE10] [RULE6]
        ADR_ACC:  r_nxt.acc = sfr_wdata; // [RULE11]
        ADR_B:    r_nxt.b   = sfr_wdata; // [RULE11]
        ADR_IE:   r_nxt.ie  = sfr_wdata;
        ADR_IP:   r_nxt.ip  = sfr_wdata;
        ADR_PEND: r_nxt.pend = sfr_wdata[N-1:0]; // [RULE20]
        default:  r_nxt.sp  = r_nxt.sp;
      endcase
    end

    // An event in the cycle of a clear still leaves its flag set.
    r_nxt.pend = r_nxt.pend | irq_event; // [RULE13]

    // Parity follows the accumulator as a flop so that the status word is fully registered.
    r_nxt.program_status_word[PSW_PAR] = ^r_nxt.acc; // [RULE9]

    if (sfr_rd) begin
      case (sfr_addr)
        ADR_SP:   r_nxt.rdata = r_r.sp;
        ADR_DPL:  r_nxt.rdata = r_r.data_ptr_low_byte;
        ADR_DPH:  r_nxt.rdata = r_r.data_ptr_high_byte;
        ADR_PSW:  r_nxt.rdata = r_r.program_status_word;
        ADR_ACC:  r_nxt.rdata = r_r.acc;
        ADR_B:    r_nxt.rdata = r_r.b;
        ADR_IE:   r_nxt.rdata = r_r.ie;
        ADR_IP:   r_nxt.rdata = r_r.ip;
        ADR_PEND: r_nxt.rdata = 8'(r_r.pend);
        default:  r_nxt.rdata = ZERO8;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      r_r    <= '0; // [RULE3] [RULE11]
      r_r.st <= ST_IDLE;
      r_r.sp <= RST_SP; // [RULE1]
    end else begin
      r_r <= r_nxt;
    end
  end

  assign sfr_rdata         = r_r.rdata;
  assign stk_wr_en         = r_r.wr_en;
  assign stk_wr_addr       = r_r.wr_adr;
  assign stk_wr_data       = r_r.wr_dat;
  assign stack_top_pointer = r_r.sp;
  assign data_ptr_16       = {r_r.data_ptr_high_byte, r_r.data_ptr_low_byte}; // [RULE3]
  assign bank_base         = {r_r.program_status_word[PSW_RS1:PSW_RS0], BANK_PAD}; // [RULE6]
  assign irq_call          = r_r.call;
  assign irq_vector        = r_r.vec;

  AST_SP_RESET: assert property (@(posedge sys_clk) rst |=> stack_top_pointer == RST_SP) // [RULE1]
    else $error("stack pointer not reloaded by reset");

  AST_PUSH_ORDER: assert property (@(posedge sys_clk) disable iff (rst) // [RULE2]
    push_req && !(sfr_wr && sfr_addr == ADR_SP)
      |=> stk_wr_en && stk_wr_addr == stack_top_pointer
          && stk_wr_addr == $past(stack_top_pointer) + STK_STEP)
    else $error("push did not pre-increment the stack pointer");

  AST_PARITY: assert property (@(posedge sys_clk) disable iff (rst) // [RULE9]
    r_r.program_status_word[PSW_PAR] == ^r_r.acc)
    else $error("parity flag disagrees with accumulator");

  AST_OV_MUL: assert property (@(posedge sys_clk) disable iff (rst) // [RULE7]
    op_valid && op_kind == OP_MUL && op_mul_hi != ZERO8 && !(sfr_wr && sfr_addr == ADR_PSW)
      |=> r_r.program_status_word[PSW_OV])
    else $error("overflow not set for large product");

  AST_OV_CLR: assert property (@(posedge sys_clk) disable iff (rst) // [RULE8]
    op_valid && (op_kind inside {OP_ADD, OP_ADDC, OP_SUBB}) && !op_sovf
      && !(sfr_wr && sfr_addr == ADR_PSW) |=> !r_r.program_status_word[PSW_OV])
    else $error("overflow not cleared");

  AST_PEND_SET: assert property (@(posedge sys_clk) disable iff (rst) // [RULE13]
    irq_event != '0 |=> (r_r.pend & $past(irq_event)) == $past(irq_event))
    else $error("event did not set its pending flag");

  AST_NO_GLOBAL: assert property (@(posedge sys_clk) disable iff (rst) // [RULE17]
    r_r.st == ST_IDLE && !r_r.ie[IE_EA] |=> r_r.st == ST_IDLE)
    else $error("dispatch with global enable cleared");

  AST_CALL_SIX: assert property (@(posedge sys_clk) disable iff (rst) // [RULE23]
    r_r.st == ST_IDLE && instr_done && !reti_done && ai.req
      |=> !irq_call [*5] ##1 irq_call)
    else $error("call did not complete six cycles after detect");

  AST_RETI_GAP: assert property (@(posedge sys_clk) disable iff (rst) // [RULE19]
    r_r.st == ST_IDLE && reti_done |=> r_r.st == ST_IDLE)
    else $error("dispatch on the return boundary");

  AST_PSW_SW: assert property (@(posedge sys_clk) disable iff (rst) // [RULE24]
    sfr_wr && sfr_addr == ADR_PSW |=> r_r.program_status_word[PSW_CY:PSW_F1] == $past(sfr_wdata[PSW_CY:PSW_F1]))
    else $error("software status write lost to hardware update");

  AST_HI_NOPREEMPT: assert property (@(posedge sys_clk) disable iff (rst) // [RULE22]
    r_r.svc_hi && r_r.st == ST_IDLE && !reti_done |=> r_r.st == ST_IDLE)
    else $error("high priority handler preempted");

  AST_RESET_REGS: assert property (@(posedge sys_clk) rst // [RULE3] [RULE11]
    |=> data_ptr_16 == {ZERO8, ZERO8} && r_r.acc == ZERO8 && r_r.b == ZERO8)
    else $error("pointer or operand register not cleared by reset");

  AST_RESET_IRQ: assert property (@(posedge sys_clk) rst // [RULE22]
    |=> r_r.ip == ZERO8 && r_r.ie == ZERO8 && r_r.pend == '0
        && r_r.st == ST_IDLE && !irq_call && !stk_wr_en)
    else $error("interrupt state not cleared by reset");

  AST_PUSH_DATA: assert property (@(posedge sys_clk) disable iff (rst) // [RULE2]
    push_req |=> stk_wr_en && stk_wr_data == $past(push_data))
    else $error("pushed byte not presented for the stack write");

  AST_POP_STEP: assert property (@(posedge sys_clk) disable iff (rst) // [RULE2]
    pop_req && !push_req && !(sfr_wr && sfr_addr == ADR_SP)
      |=> !stk_wr_en && stack_top_pointer == $past(stack_top_pointer) - STK_STEP)
    else $error("pop did not step the stack pointer down");

  AST_DPL_WRITE: assert property (@(posedge sys_clk) disable iff (rst) // [RULE3]
    sfr_wr && sfr_addr == ADR_DPL |=> data_ptr_16 == {r_r.data_ptr_high_byte, $past(sfr_wdata)})
    else $error("low pointer byte not written");

  AST_DPH_WRITE: assert property (@(posedge sys_clk) disable iff (rst) // [RULE3]
    sfr_wr && sfr_addr == ADR_DPH |=> data_ptr_16 == {$past(sfr_wdata), r_r.data_ptr_low_byte})
    else $error("high pointer byte not written");

  AST_CY_FOLLOW: assert property (@(posedge sys_clk) disable iff (rst) // [RULE4]
    op_valid && !(sfr_wr && sfr_addr == ADR_PSW) |=> r_r.program_status_word[PSW_CY] == $past(op_cy))
    else $error("carry flag does not follow the operation");

  AST_AC_FOLLOW: assert property (@(posedge sys_clk) disable iff (rst) // [RULE5]
    op_valid && !(sfr_wr && sfr_addr == ADR_PSW) |=> r_r.program_status_word[PSW_AC] == $past(op_ac))
    else $error("nibble carry flag does not follow the operation");

  AST_BANK_SEL: assert property (@(posedge sys_clk) disable iff (rst) // [RULE6]
    sfr_wr && sfr_addr == ADR_PSW |=> bank_base == {$past(sfr_wdata[PSW_RS1:PSW_RS0]), BANK_PAD})
    else $error("bank base does not follow the bank select bits");

  AST_OV_SIGNED: assert property (@(posedge sys_clk) disable iff (rst) // [RULE7]
    op_valid && (op_kind inside {OP_ADD, OP_ADDC, OP_SUBB}) && op_sovf
      && !(sfr_wr && sfr_addr == ADR_PSW) |=> r_r.program_status_word[PSW_OV])
    else $error("overflow not set for signed overflow");

  AST_OV_DIV: assert property (@(posedge sys_clk) disable iff (rst) // [RULE7]
    op_valid && op_kind == OP_DIV && r_r.b == ZERO8
      && !(sfr_wr && sfr_addr == ADR_PSW) |=> r_r.program_status_word[PSW_OV])
    else $error("overflow not set for divide by zero");

  AST_OV_MULDIV_CLR: assert property (@(posedge sys_clk) disable iff (rst) // [RULE8]
    op_valid && ((op_kind == OP_MUL && op_mul_hi == ZERO8) || (op_kind == OP_DIV && r_r.b != ZERO8))
      && !(sfr_wr && sfr_addr == ADR_PSW)
      |=> !r_r.program_status_word[PSW_OV])
    else $error("overflow not cleared after multiply or divide");

  AST_OV_OTHER_KEEP: assert property (@(posedge sys_clk) disable iff (rst) // [RULE8]
    op_valid && op_kind == OP_OTHER && !(sfr_wr && sfr_addr == ADR_PSW)
      |=> $stable(r_r.program_status_word[PSW_OV]))
    else $error("overflow changed by an operation that leaves it alone");

  AST_USER_FLAGS: assert property (@(posedge sys_clk) disable iff (rst) // [RULE10] [RULE6]
    !(sfr_wr && sfr_addr == ADR_PSW)
      |=> $stable(r_r.program_status_word[PSW_F1]) && $stable(r_r.program_status_word[PSW_RS1:PSW_RS0]))
    else $error("user flag or bank select changed without a software write");

  AST_NO_DISABLED: assert property (@(posedge sys_clk) disable iff (rst) // [RULE16]
    r_r.st == ST_IDLE && (r_r.pend & r_r.ie[N-1:0]) == '0 |=> r_r.st == ST_IDLE)
    else $error("dispatch without an enabled pending source");

  AST_PEND_HWCLR: assert property (@(posedge sys_clk) disable iff (rst) // [RULE18]
    r_r.st == ST_IDLE && instr_done && !reti_done && ai.req && HW_CLR[ai.idx]
      && !irq_event[ai.idx] && !(sfr_wr && sfr_addr == ADR_PEND)
      |=> !r_r.pend[$past(ai.idx)])
    else $error("designated pending flag not cleared on vectoring");

  AST_PEND_KEEP: assert property (@(posedge sys_clk) disable iff (rst) // [RULE18]
    r_r.st == ST_IDLE && instr_done && !reti_done && ai.req && !HW_CLR[ai.idx]
      && !(sfr_wr && sfr_addr == ADR_PEND)
      |=> r_r.pend[$past(ai.idx)])
    else $error("software cleared pending flag dropped by hardware");

  AST_VECTOR: assert property (@(posedge sys_clk) disable iff (rst) // [RULE14]
    r_r.st == ST_IDLE && instr_done && !reti_done && ai.req
      |=> irq_vector == (VEC_BASE | (16'($past(ai.idx)) << VEC_SHIFT)))
    else $error("vector does not match the dispatched source");

  AST_SOFT_REQ: assert property (@(posedge sys_clk) disable iff (rst) // [RULE20]
    sfr_wr && sfr_addr == ADR_PEND |=> r_r.pend == ($past(sfr_wdata[N-1:0]) | $past(irq_event)))
    else $error("software write to the pending flags lost");

  AST_RETI_HI: assert property (@(posedge sys_clk) disable iff (rst) // [RULE15]
    reti_done && r_r.svc_hi |=> !r_r.svc_hi)
    else $error("return left the high level in service");

  AST_RETI_LO: assert property (@(posedge sys_clk) disable iff (rst) // [RULE15]
    reti_done && !r_r.svc_hi |=> !r_r.svc_lo)
    else $error("return left the low level in service");

  AST_CALL_PULSE: assert property (@(posedge sys_clk) disable iff (rst) // [RULE23]
    irq_call |=> !irq_call)
    else $error("call strobe longer than one cycle");

  AST_HI_ENTRY: assert property (@(posedge sys_clk) disable iff (rst) // [RULE21] [RULE22]
    r_r.st == ST_IDLE && instr_done && !reti_done && ai.req && ai.hi
      |=> r_r.svc_hi && r_r.ip[$past(ai.idx)])
    else $error("high level request not entered at high level");
endmodule
`default_nettype wire

// >>> tb/csr_core_regs_test.sv
/*
  Self-checking bench for the core status registers and interrupt entry.
  Assumes csr_pkg is compiled first and the block uses its default seven sources.
*/
`timescale 1ns/1ps
`default_nettype none
module csr_core_regs_test;
  import csr_pkg::*;
  logic        sys_clk, rst, sfr_wr, sfr_rd, op_valid, op_cy, op_ac, op_sovf;
  logic        acc_wr, push_req, pop_req, instr_done, reti_done, stk_wr_en, irq_call;
  logic [7:0]  sfr_addr, sfr_wdata, op_mul_hi, acc_data, push_data, sfr_rdata;
  logic [7:0]  stk_wr_addr, stk_wr_data, stack_top_pointer;
  logic [15:0] data_ptr_16, irq_vector;
  logic [4:0]  bank_base;
  logic [6:0]  irq_event;
  csr_op_e     op_kind;
  int          n_errors, comparisons;

  csr_core_regs DUT (.sys_clk, .rst, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata,
    .op_valid, .op_kind, .op_cy, .op_ac, .op_sovf, .op_mul_hi, .acc_wr, .acc_data,
    .push_req, .push_data, .pop_req, .stk_wr_en, .stk_wr_addr, .stk_wr_data,
    .stack_top_pointer, .data_ptr_16, .bank_base, .irq_event, .instr_done, .reti_done,
    .irq_call, .irq_vector);

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge sys_clk);
    sfr_wr <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge sys_clk);
    sfr_rd <= 1'b0;
    #1;
    chk({8'h00, sfr_rdata}, {8'h00, exp});
  endtask

  // The optional status write lands in the same cycle as the flag update.
  task automatic op(input csr_op_e k, input logic [2:0] f, input logic [7:0] mh, input logic w);
    @(posedge sys_clk);
    op_valid  <= 1'b1;
    op_kind   <= k;
    {op_cy, op_ac, op_sovf} <= f;
    op_mul_hi <= mh;
    sfr_addr  <= ADR_PSW;
    sfr_wdata <= 8'h00;
    sfr_wr    <= w;
    @(posedge sys_clk);
    op_valid <= 1'b0;
    sfr_wr   <= 1'b0;
  endtask

  // Ends an instruction and counts cycles to the call; eight means none came.
  task automatic go(input logic ret, input logic call, input logic [15:0] vec);
    int k;
    @(posedge sys_clk);
    instr_done <= 1'b1;
    reti_done  <= ret;
    @(posedge sys_clk);
    instr_done <= 1'b0;
    reti_done  <= 1'b0;
    #1;
    k = 0;
    while (irq_call !== 1'b1 && k < 8) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    chk(16'(k), call ? 16'h0005 : 16'h0008);
    if (call) chk(irq_vector, vec);
  endtask

  task automatic t_reset();
    chk({8'h00, stack_top_pointer}, 16'h0007);
    chk(data_ptr_16, 16'h0000);
    rdc(ADR_SP, 8'h07);
    rdc(ADR_DPL, 8'h00);
    rdc(ADR_DPH, 8'h00);
    rdc(ADR_ACC, 8'h00);
    rdc(ADR_B, 8'h00);
    rdc(ADR_PSW, 8'h00);
    rdc(ADR_IP, 8'h00);
  endtask

  task automatic t_stack();
    @(posedge sys_clk);
    push_req  <= 1'b1;
    push_data <= 8'ha5;
    @(posedge sys_clk);
    push_data <= 8'h3c;
    #1;
    chk({7'h00, stk_wr_en, stk_wr_addr}, 16'h0108);
    chk({stk_wr_data, stack_top_pointer}, 16'ha508);
    @(posedge sys_clk);
    push_req <= 1'b0;
    pop_req  <= 1'b1;
    #1;
    chk({stk_wr_addr, stk_wr_data}, 16'h093c);
    @(posedge sys_clk);
    pop_req <= 1'b0;
    #1;
    chk({7'h00, stk_wr_en, stack_top_pointer}, 16'h0008);
    wr(ADR_SP, 8'h30);
    rdc(ADR_SP, 8'h30);
    wr(ADR_SP, 8'h07);
  endtask

  task automatic t_data_ptr_16();
    wr(ADR_DPL, 8'h34);
    wr(ADR_DPH, 8'h12);
    @(posedge sys_clk);
    #1;
    chk(data_ptr_16, 16'h1234);
    rdc(ADR_DPL, 8'h34);
  endtask

  task automatic t_flags();
    op(OP_ADD, 3'h7, 8'h00, 1'b0);
    rdc(ADR_PSW, 8'hc4);
    op(OP_ADD, 3'h0, 8'h00, 1'b0);
    rdc(ADR_PSW, 8'h00);
    op(OP_SUBB, 3'h1, 8'h00, 1'b0);
    rdc(ADR_PSW, 8'h04);
    op(OP_OTHER, 3'h0, 8'h00, 1'b0);
    rdc(ADR_PSW, 8'h04);
    op(OP_MUL, 3'h0, 8'h00, 1'b0);
    rdc(ADR_PSW, 8'h00);
    op(OP_MUL, 3'h0, 8'h01, 1'b0);
    rdc(ADR_PSW, 8'h04);
    op(OP_ADDC, 3'h0, 8'h00, 1'b0);
    rdc(ADR_PSW, 8'h00);
    op(OP_DIV, 3'h0, 8'h00, 1'b0);
    rdc(ADR_PSW, 8'h04);
    wr(ADR_B, 8'h03);
    op(OP_DIV, 3'h0, 8'h00, 1'b0);
    rdc(ADR_PSW, 8'h00);
    op(OP_ADD, 3'h7, 8'h00, 1'b1);
    rdc(ADR_PSW, 8'h00);
  endtask

  task automatic t_status_sw();
    for (int i = 0; i < 4; i++) begin
      wr(ADR_PSW, 8'(i * 8));
      @(posedge sys_clk);
      #1;
      chk({11'h000, bank_base}, 16'(i * 8));
    end
    wr(ADR_PSW, 8'hff);
    rdc(ADR_PSW, 8'hfe);
    op(OP_ADD, 3'h0, 8'h00, 1'b0);
    rdc(ADR_PSW, 8'h3a);
    wr(ADR_PSW, 8'h00);
  endtask

  task automatic t_acc();
    @(posedge sys_clk);
    acc_wr   <= 1'b1;
    acc_data <= 8'h07;
    @(posedge sys_clk);
    acc_wr <= 1'b0;
    rdc(ADR_ACC, 8'h07);
    rdc(ADR_PSW, 8'h01);
    wr(ADR_ACC, 8'h03);
    rdc(ADR_PSW, 8'h00);
    wr(ADR_B, 8'h5a);
    rdc(ADR_B, 8'h5a);
    wr(8'h90, 8'h00);
    rdc(8'h90, 8'h00);
  endtask

  task automatic t_irq_gate();
    @(posedge sys_clk);
    irq_event <= 7'h10;
    @(posedge sys_clk);
    irq_event <= 7'h00;
    rdc(ADR_PEND, 8'h10);
    go(1'b0, 1'b0, 16'h0000);
    wr(ADR_IE, 8'h10);
    go(1'b0, 1'b0, 16'h0000);
    wr(ADR_IE, 8'h90);
    go(1'b0, 1'b1, 16'h0023);
    rdc(ADR_PEND, 8'h10);
    go(1'b1, 1'b0, 16'h0000);
    go(1'b0, 1'b1, 16'h0023);
    wr(ADR_PEND, 8'h00);
    go(1'b1, 1'b0, 16'h0000);
  endtask

  task automatic t_irq_soft();
    wr(ADR_IE, 8'h82);
    wr(ADR_PEND, 8'h02);
    go(1'b0, 1'b1, 16'h000b);
    rdc(ADR_PEND, 8'h00);
    go(1'b1, 1'b0, 16'h0000);
  endtask

  // Source 2 is high, source 0 low; both raised together to see the level win.
  task automatic t_irq_prio();
    wr(ADR_IP, 8'h04);
    wr(ADR_IE, 8'h85);
    wr(ADR_PEND, 8'h05);
    go(1'b0, 1'b1, 16'h0013);
    go(1'b0, 1'b0, 16'h0000);
    go(1'b1, 1'b0, 16'h0000);
    go(1'b0, 1'b1, 16'h0003);
    wr(ADR_PEND, 8'h04);
    go(1'b0, 1'b1, 16'h0013);
    go(1'b1, 1'b0, 16'h0000);
    go(1'b1, 1'b0, 16'h0000);
  endtask

  task automatic finish_test();
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #100000;
    n_errors++;
    finish_test();
  end

  initial begin
    n_errors = 0;
    comparisons = 0;
    {rst, sfr_wr, sfr_rd, op_valid, op_cy, op_ac, op_sovf} = 7'h40;
    {acc_wr, push_req, pop_req, instr_done, reti_done} = 5'h00;
    {sfr_addr, sfr_wdata, op_mul_hi, acc_data, push_data} = 40'h0;
    irq_event = 7'h00;
    op_kind = OP_OTHER;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    t_reset();
    t_stack();
    t_data_ptr_16();
    t_flags();
    t_status_sw();
    t_acc();
    t_irq_gate();
    t_irq_soft();
    t_irq_prio();
    finish_test();
  end
endmodule
`default_nettype wire
